// ===== include/fir_input_pkg.sv
/*
  Shared constants and types for the FIR sample and coefficient input stage:
  cell word layout, register offsets, field positions and reset values.
  Assumes a single 125 MHz system clock and a synchronous reset.
*/
package fir_input_pkg;

  localparam int unsigned CELL_COUNT   = 8;
  localparam int unsigned VALUE_W      = 8;
  localparam int unsigned FIFO_DEPTH   = 32;
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned DATA_W       = 32;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] STATUS_OFS    = 8'h04;
  localparam logic [7:0] COEF_OFS      = 8'h08;
  localparam logic [7:0] SAMPLE_OFS    = 8'h0c;
  localparam logic [7:0] FIFO_DATA_OFS = 8'h10;

  localparam int unsigned CTRL_CAPTURE_BIT   = 0;
  localparam int unsigned STATUS_LEVEL_LSB   = 0;
  localparam int unsigned STATUS_EMPTY_BIT   = 8;
  localparam int unsigned STATUS_FULL_BIT    = 9;
  localparam int unsigned STATUS_OVERRUN_BIT = 10;

  localparam logic       CTRL_CAPTURE_RST = 1'b0;
  localparam logic       LOAD_EN_N_RST    = 1'b1;
  localparam logic [1:0] RESP_OKAY        = 2'b00;
  localparam logic [1:0] RESP_SLVERR      = 2'b10;

  // Eight value bits plus the number-format flag captured with them
  typedef struct packed {
    logic                 fmt_signed;
    logic [VALUE_W-1:0]   value;
  } cell_word_s;

  localparam cell_word_s CELL_ZERO = '{fmt_signed: 1'b0, value: 8'h00};

  // Widen by format flag: unsigned zero-fills, two's complement sign-fills
  function automatic logic [DATA_W-1:0] widen(input cell_word_s w);
    logic fill;
    fill = w.fmt_signed & w.value[VALUE_W-1];
    widen = {{(DATA_W-VALUE_W){fill}}, w.value};
  endfunction

endpackage

// ===== rtl/fir_input_stage.sv
/*
  FIR input stage: broadcasts samples into every cell's sample register,
  loads coefficients into cell 0, and queues captured samples for software
  behind an AXI4-Lite slave. Pins come from logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

// ---------------------------------------------------------------------
// Word FIFO
// ---------------------------------------------------------------------
module word_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic                       clk_sys,
  input  wire logic                       srst,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  output logic [$clog2(DEPTH):0]          level
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    rd_q;
  logic [PW:0]      count_q;
  logic [PW:0]      count_d;
  logic             push;
  logic             pop;

  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;
  assign out_data = mem_q[rd_q];
  assign level    = count_q;

  always_comb
  begin
    count_d = count_q;
    if (push && !pop)
      count_d = count_q + 1'b1;
    else if (pop && !push)
      count_d = count_q - 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end

  // Flags are registered so full and empty never depend on this cycle's pop
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      wr_q      <= '0;
      rd_q      <= '0;
      count_q   <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
      count_q   <= count_d;
      in_ready  <= count_d != (PW+1)'(DEPTH);
      out_valid <= count_d != '0;
    end
  end
endmodule

// What this block does
// - A clock edge with the delayed sample enable low loads the sample bus into every cell's sample register at once.
// - With the delayed sample enable high the sample bus is forced to zero, so every edge loads zero into all cells.
// - The sample enable is registered one clock, so the source drops it the cycle before the wanted sample.
// - A low sample format select marks samples unsigned, a high one marks them two's complement.
// - The sample format select is captured with the sample, on the same edge and the same delayed enable.
// - A clock edge with the delayed coefficient enable low loads the coefficient input into cell 0 only.
// - The coefficient enable is registered one clock, so the source drops it the cycle before the coefficient.
// - A low coefficient format select marks coefficients unsigned, a high one two's complement.
// - The coefficient format select is captured with the coefficient bits under the same edge and enable.
// - While the delayed coefficient enable is high the coefficient register holds its contents.
module fir_input_stage
  import fir_input_pkg::*;
#(
  parameter int unsigned CELLS = fir_input_pkg::CELL_COUNT,
  parameter int unsigned DEPTH = fir_input_pkg::FIFO_DEPTH
) (
  input  wire logic                               clk_sys,
  input  wire logic                               srst,
  input  wire logic [fir_input_pkg::VALUE_W-1:0]  sample_in,
  input  wire logic                               sample_signed_sel,
  input  wire logic                               sample_load_en_n,
  input  wire logic [fir_input_pkg::VALUE_W-1:0]  coef_in,
  input  wire logic                               coef_signed_sel,
  input  wire logic                               coef_load_en_n,
  output fir_input_pkg::cell_word_s [CELLS-1:0]   sample_cells,
  output fir_input_pkg::cell_word_s               coef_cell0,
  output logic                                    sample_fifo_ready,
  input  wire logic [fir_input_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                               s_axi_awvalid,
  output logic                                    s_axi_awready,
  input  wire logic [fir_input_pkg::DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]                         s_axi_wstrb,
  input  wire logic                               s_axi_wvalid,
  output logic                                    s_axi_wready,
  output logic [1:0]                              s_axi_bresp,
  output logic                                    s_axi_bvalid,
  input  wire logic                               s_axi_bready,
  input  wire logic [fir_input_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                               s_axi_arvalid,
  output logic                                    s_axi_arready,
  output logic [fir_input_pkg::DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                              s_axi_rresp,
  output logic                                    s_axi_rvalid,
  input  wire logic                               s_axi_rready
);
  import fir_input_pkg::*;

  localparam int unsigned LW = $clog2(DEPTH) + 1;

  logic             sample_en_n_q;
  logic             coef_en_n_q;
  cell_word_s       sample_bus;
  logic             capture_q;
  logic             overrun_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [3:0]       wstrb_q;
  logic             aw_held_q;
  logic             w_held_q;
  logic             wr_fire;
  logic             rd_take;
  logic             fifo_push;
  logic             fifo_valid;
  logic             fifo_pop;
  cell_word_s       fifo_head;
  logic [LW-1:0]    fifo_level;

  // ---------------------------------------------------------------------
  // Load enables and cell registers
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      sample_en_n_q <= LOAD_EN_N_RST;
      coef_en_n_q   <= LOAD_EN_N_RST;
    end
    else
    begin
      sample_en_n_q <= sample_load_en_n;
      coef_en_n_q   <= coef_load_en_n;
    end
  end

  // Disabled bus reads as zero, flag included, so idle edges clear every cell
  assign sample_bus = sample_en_n_q ? CELL_ZERO
                    : '{fmt_signed: sample_signed_sel,
                        value: sample_in};

  for (genvar c = 0; c < CELLS; c++)
  begin : g_cell
    always_ff @(posedge clk_sys)
    begin
      if (srst)
        sample_cells[c] <= CELL_ZERO;
      else
        sample_cells[c] <= sample_bus;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      coef_cell0 <= CELL_ZERO;
    else if (!coef_en_n_q)
      coef_cell0 <= '{fmt_signed: coef_signed_sel, value: coef_in};
  end

  // ---------------------------------------------------------------------
  // Sample capture queue
  // ---------------------------------------------------------------------
  // The pin source cannot be stalled; sample_fifo_ready tells it to pause
  assign fifo_push = capture_q && !sample_en_n_q;

  word_fifo #(.WIDTH($bits(cell_word_s)), .DEPTH(DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .in_valid  (fifo_push),
    .in_ready  (sample_fifo_ready),
    .in_data   (sample_bus),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_head),
    .level     (fifo_level)
  );

  // ---------------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------------
  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_held_q;
      s_axi_wready  <= s_axi_wvalid && !s_axi_wready && !w_held_q;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_q == CTRL_OFS || awaddr_q == STATUS_OFS)
          s_axi_bresp <= RESP_OKAY;
        else
          s_axi_bresp <= RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      capture_q <= CTRL_CAPTURE_RST;
    else if (wr_fire && awaddr_q == CTRL_OFS && wstrb_q[0])
      capture_q <= wdata_q[CTRL_CAPTURE_BIT];
  end

  // Overrun sets on a push into a full queue; a set beats a same-cycle clear
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      overrun_q <= 1'b0;
    else if (fifo_push && !sample_fifo_ready)
      overrun_q <= 1'b1;
    else if (wr_fire && awaddr_q == STATUS_OFS && wstrb_q[1]
             && wdata_q[STATUS_OVERRUN_BIT])
      overrun_q <= 1'b0;
  end

  // ---------------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------------
  assign rd_take  = s_axi_arvalid && s_axi_arready;
  assign fifo_pop = rd_take && s_axi_araddr == FIFO_DATA_OFS;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        if (s_axi_araddr == CTRL_OFS)
          s_axi_rdata <= DATA_W'(capture_q);
        else if (s_axi_araddr == STATUS_OFS)
          s_axi_rdata <= DATA_W'({overrun_q, !sample_fifo_ready,
                                  !fifo_valid, 2'b00, fifo_level});
        else if (s_axi_araddr == COEF_OFS)
          s_axi_rdata <= widen(coef_cell0);
        else if (s_axi_araddr == SAMPLE_OFS)
          s_axi_rdata <= widen(sample_cells[0]);
        else if (s_axi_araddr == FIFO_DATA_OFS)
          s_axi_rdata <= fifo_valid ? widen(fifo_head) : '0;
        else
        begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  property p_sample_bcast;
    @(posedge clk_sys) disable iff (srst)
      (!$past(sample_load_en_n, 2) && !$past(srst))
      |-> sample_cells[CELLS-1].value == $past(sample_in)
          && sample_cells[0] == sample_cells[CELLS-1];
  endproperty
  a_sample_bcast: assert property (p_sample_bcast)
    else $error("sample not broadcast to all cells");

  property p_sample_zero;
    @(posedge clk_sys) disable iff (srst)
      ($past(sample_load_en_n, 2) && !$past(srst))
      |-> sample_cells[CELLS/2] == CELL_ZERO;
  endproperty
  a_sample_zero: assert property (p_sample_zero)
    else $error("disabled sample bus did not load zero");

  property p_sample_late;
    @(posedge clk_sys) disable iff (srst)
      $fell(sample_load_en_n) ##1 !$past(srst) |-> sample_cells[0] == CELL_ZERO;
  endproperty
  a_sample_late: assert property (p_sample_late)
    else $error("sample enable acted without its clock of delay");

  property p_sample_fmt;
    @(posedge clk_sys) disable iff (srst)
      (!$past(sample_load_en_n, 2) && !$past(srst))
      |-> sample_cells[1].fmt_signed == $past(sample_signed_sel);
  endproperty
  a_sample_fmt: assert property (p_sample_fmt)
    else $error("sample format flag not captured with sample");

  property p_coef_load;
    @(posedge clk_sys) disable iff (srst)
      (!$past(coef_load_en_n, 2) && !$past(srst))
      |-> coef_cell0 == {$past(coef_signed_sel), $past(coef_in)};
  endproperty
  a_coef_load: assert property (p_coef_load)
    else $error("coefficient not loaded into cell 0");

  property p_coef_hold;
    @(posedge clk_sys) disable iff (srst)
      ($past(coef_load_en_n, 2) && !$past(srst)) |-> $stable(coef_cell0);
  endproperty
  a_coef_hold: assert property (p_coef_hold)
    else $error("coefficient register changed while frozen");

  property p_coef_sign;
    @(posedge clk_sys) disable iff (srst)
      (rd_take && s_axi_araddr == COEF_OFS)
      |=> s_axi_rdata[DATA_W-1] ==
          ($past(coef_cell0.fmt_signed) && $past(coef_cell0.value[VALUE_W-1]));
  endproperty
  a_coef_sign: assert property (p_coef_sign)
    else $error("coefficient read back with wrong number format");

  property p_bresp_hold;
    @(posedge clk_sys) disable iff (srst)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold)
    else $error("write response dropped before bready");

  c_sample_run: cover property (@(posedge clk_sys) disable iff (srst)
    !sample_load_en_n [*4]);
  c_coef_load: cover property (@(posedge clk_sys) disable iff (srst)
    $fell(coef_load_en_n) ##2 coef_cell0.fmt_signed);
  c_fifo_full: cover property (@(posedge clk_sys) disable iff (srst)
    !sample_fifo_ready);
endmodule

`default_nettype wire

// ===== testbench/fir_source_model.sv
/*
  Upstream source model: puts samples and coefficients on the filter pins,
  dropping each load enable one cycle ahead of its word.
  Assumes the same clock as the filter and a request strobe from the bench.
*/
`timescale 1ns/100ps
`default_nettype none

module fir_source_model
  import fir_input_pkg::*;
(
  input  wire logic                         clk_sys,
  input  wire logic                         srst,
  input  wire logic                         req,
  input  wire logic                         req_load_s,
  input  wire logic                         req_load_c,
  input  wire fir_input_pkg::cell_word_s    req_sample,
  input  wire fir_input_pkg::cell_word_s    req_coef,
  output logic [fir_input_pkg::VALUE_W-1:0] sample_in,
  output logic                              sample_signed_sel,
  output logic                              sample_load_en_n,
  output logic [fir_input_pkg::VALUE_W-1:0] coef_in,
  output logic                              coef_signed_sel,
  output logic                              coef_load_en_n
);
  logic       pend_q;
  cell_word_s s_q;
  cell_word_s c_q;

  initial
  begin
    {sample_signed_sel, sample_in} = 9'h0a5;
    {coef_signed_sel, coef_in} = 9'h15a;
    sample_load_en_n = 1'b1;
    coef_load_en_n = 1'b1;
    pend_q = 1'b0;
  end

  // ---------------------------------------------------------------------
  // Enables lead their word by one cycle
  // ---------------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    sample_load_en_n <= srst | ~(req & req_load_s);
    coef_load_en_n <= srst | ~(req & req_load_c);
    pend_q <= req & ~srst;
    s_q <= req_sample;
    c_q <= req_coef;
  end

  // ---------------------------------------------------------------------
  // Data slot; off-slot lines invert so a stale word never looks valid
  // ---------------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (pend_q)
    begin
      {sample_signed_sel, sample_in} <= s_q;
      {coef_signed_sel, coef_in} <= c_q;
    end
    else
    begin
      {sample_signed_sel, sample_in} <= ~{sample_signed_sel, sample_in};
      {coef_signed_sel, coef_in} <= ~{coef_signed_sel, coef_in};
    end
  end
endmodule

`default_nettype wire

// ===== testbench/tb.sv
/*
  Self-checking bench for the FIR input stage: pin loading through the
  source model, register access over AXI4-Lite, capture queue fill/drain.
  Assumes the filter package and the source model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  $display("Error %s expected %h seen %h", nm, e, g); n_errors++; end end

module tb;
  import fir_input_pkg::*;

  logic             clk_sys;
  logic             srst;
  logic             req;
  logic             req_load_s;
  logic             req_load_c;
  cell_word_s       req_sample;
  cell_word_s       req_coef;
  logic [7:0]       sample_in;
  logic [7:0]       coef_in;
  logic             sample_signed_sel;
  logic             sample_load_en_n;
  logic             coef_signed_sel;
  logic             coef_load_en_n;
  cell_word_s [7:0] sample_cells;
  cell_word_s       coef_cell0;
  logic             sample_fifo_ready;
  logic [7:0]       s_axi_awaddr;
  logic [7:0]       s_axi_araddr;
  logic [31:0]      s_axi_wdata;
  logic [31:0]      s_axi_rdata;
  logic [3:0]       s_axi_wstrb;
  logic [1:0]       s_axi_bresp;
  logic [1:0]       s_axi_rresp;
  logic             s_axi_awvalid;
  logic             s_axi_awready;
  logic             s_axi_wvalid;
  logic             s_axi_wready;
  logic             s_axi_bvalid;
  logic             s_axi_bready;
  logic             s_axi_arvalid;
  logic             s_axi_arready;
  logic             s_axi_rvalid;
  logic             s_axi_rready;
  int               n_errors;
  int               total_checks;

  fir_source_model u_src (.clk_sys(clk_sys), .srst(srst), .req(req),
    .req_load_s(req_load_s), .req_load_c(req_load_c),
    .req_sample(req_sample), .req_coef(req_coef), .sample_in(sample_in),
    .sample_signed_sel(sample_signed_sel),
    .sample_load_en_n(sample_load_en_n), .coef_in(coef_in),
    .coef_signed_sel(coef_signed_sel), .coef_load_en_n(coef_load_en_n));

  fir_input_stage #(.CELLS(8), .DEPTH(32)) u_dut (.clk_sys(clk_sys),
    .srst(srst), .sample_in(sample_in),
    .sample_signed_sel(sample_signed_sel),
    .sample_load_en_n(sample_load_en_n), .coef_in(coef_in),
    .coef_signed_sel(coef_signed_sel), .coef_load_en_n(coef_load_en_n),
    .sample_cells(sample_cells), .coef_cell0(coef_cell0),
    .sample_fifo_ready(sample_fifo_ready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  // ---------------------------------------------------------------------
  // Bus tasks; the master waits for the answer, only the watchdog ends it
  // ---------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    int n;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    `CHK("read data", e, d)
    `CHK("read resp", RESP_OKAY, r)
  endtask

  // One word through the model; returns just after the loading edge
  task automatic push(input cell_word_s s, input cell_word_s c,
                      input logic ls, input logic lc);
    @(posedge clk_sys);
    req <= 1'b1;
    req_sample <= s;
    req_coef <= c;
    req_load_s <= ls;
    req_load_c <= lc;
    @(posedge clk_sys);
    req <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic cells_chk(input cell_word_s e);
    for (int c = 0; c < 8; c++)
      `CHK("sample cell", e, sample_cells[c])
  endtask

  function automatic logic [31:0] wide(input cell_word_s w);
    wide = (w.fmt_signed && w.value[7]) ? {24'hffffff, w.value}
                                        : {24'h000000, w.value};
  endfunction

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_reset;
    #1;
    cells_chk(CELL_ZERO);
    `CHK("coef reset", CELL_ZERO, coef_cell0)
    `CHK("fifo ready", 1'b1, sample_fifo_ready)
    rd_chk(CTRL_OFS, 32'h00000000);
    rd_chk(STATUS_OFS, 32'h00000100);
    rd_chk(SAMPLE_OFS, 32'h00000000);
  endtask

  // Every format combination, then idle cycle and a sample-only load
  task automatic t_load;
    cell_word_s s;
    cell_word_s c;
    for (int k = 0; k < 4; k++)
    begin
      s = '{k[0], 8'(8'h85 + k)};
      c = '{k[1], 8'(8'h9a - k)};
      push(s, c, 1'b1, 1'b1);
      cells_chk(s);
      `CHK("coef cell0", c, coef_cell0)
      @(posedge clk_sys);
      #1;
      cells_chk(CELL_ZERO);
      `CHK("coef hold", c, coef_cell0)
      rd_chk(COEF_OFS, wide(c));
    end
    push('{1'b1, 8'h7e}, ~c, 1'b1, 1'b0);
    `CHK("coef no load", c, coef_cell0)
    `CHK("cell width", 9, $bits(sample_cells[0]))
  endtask

  // Two samples in consecutive cycles, then the bus drops to zero
  task automatic t_b2b;
    @(posedge clk_sys);
    req <= 1'b1;
    req_load_s <= 1'b1;
    req_load_c <= 1'b0;
    req_sample <= '{1'b0, 8'hc3};
    @(posedge clk_sys);
    req_sample <= '{1'b1, 8'h3c};
    @(posedge clk_sys);
    req <= 1'b0;
    @(posedge clk_sys);
    #1;
    cells_chk('{1'b0, 8'hc3});
    @(posedge clk_sys);
    #1;
    cells_chk('{1'b1, 8'h3c});
    @(posedge clk_sys);
    #1;
    cells_chk(CELL_ZERO);
  endtask

  // Fill the queue past full, then drain it and clear the overrun
  task automatic t_fifo;
    logic [1:0] r;
    wr(CTRL_OFS, 32'h1, 4'h1, r);
    for (int i = 0; i < 33; i++)
      push('{i[0], 8'(8'h80 + i)}, CELL_ZERO, 1'b1, 1'b0);
    `CHK("fifo full", 1'b0, sample_fifo_ready)
    rd_chk(STATUS_OFS, 32'h00000620);
    wr(CTRL_OFS, 32'h0, 4'h1, r);
    for (int i = 0; i < 32; i++)
      rd_chk(FIFO_DATA_OFS, wide('{i[0], 8'(8'h80 + i)}));
    rd_chk(STATUS_OFS, 32'h00000500);
    wr(STATUS_OFS, 32'h400, 4'h2, r);
    `CHK("clear resp", RESP_OKAY, r)
    rd_chk(STATUS_OFS, 32'h00000100);
    rd_chk(FIFO_DATA_OFS, 32'h0);
  endtask

  task automatic t_errors;
    logic [31:0] d;
    logic [1:0]  r;
    rd(8'h20, d, r);
    `CHK("unmapped resp", RESP_SLVERR, r)
    `CHK("unmapped data", 32'h0, d)
    wr(COEF_OFS, 32'hff, 4'hf, r);
    `CHK("read-only resp", RESP_SLVERR, r)
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ---------------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ---------------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  initial
  begin
    n_errors = 0;
    total_checks = 0;
    {req, req_load_s, req_load_c} = 3'h0;
    req_sample = CELL_ZERO;
    req_coef = CELL_ZERO;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    srst = 1'b1;
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset();
    t_load();
    t_b2b();
    t_fifo();
    t_errors();
    wrap_up();
  end

  // Whole run needs well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    wrap_up();
  end
endmodule

`default_nettype wire
